// ### ioc_channel_ctrl.sv
// What this block does
// - one DAC range bit for all channels
// - DAC takes 12-bit straight binary code
// - DAC output updates right after write
// - hold mode defers DAC updates, apply together
// - sequence register picks channels, sequencer steps
// - first channel tracks after sequence write
// - conversion starts at address acknowledge clock
// - conversion completes within conversion time
// - one ADC range bit for all channels
// - ADC result is 12-bit straight binary
// - DAC drives pin, ADC still converts
// - GPIO input and output config registers
// - output pins follow GPIO data bits
// - pointer 0x60 selects input pin readback
// - input read back shows only pins set as inputs
// - reference off after reset, bit enables
// - reset pin falling edge restores defaults
// - reset done within 250 us busy
// - pattern write to reset register resets
// - pointer high nibble zero selects control
// - write is pointer, high, low byte
// - lock bit blocks pin config writes
module ioc_channel_ctrl
  import ioc_pkg::*;
#(
  parameter int CODE_W = 12,
  parameter int RESET_CYC = RESET_CYCLES
) (
  // system
  input wire logic clk_sys,
  input wire logic rst_n,
  // serial link
  input wire logic scl_link,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic addr_a0,
  // reset pin
  input wire logic reset_pin_n,
  // analog side
  output logic [7:0][CODE_W-1:0] dac_code,
  output logic dac_gain2,
  output logic adc_gain2,
  output logic ref_enable,
  output logic [7:0] dac_en,
  output logic [7:0] adc_en,
  output logic [7:0] pulldown_en,
  output logic [2:0] adc_mux_sel,
  output logic adc_track,
  output logic adc_convert,
  input wire logic [CODE_W-1:0] adc_code_in,
  // digital pins
  input wire logic [7:0] io_in,
  output logic [7:0] io_out,
  output logic [7:0] io_oe,
  // status
  output logic reset_busy
);
  localparam int BW = $clog2(RESET_CYC + 1);
  localparam logic [7:0] TRK_C = 8'(TRACK_CYCLES);
  localparam logic [7:0] CNV_C = 8'(CONV_CYCLES);
  localparam logic [BW-1:0] RST_C = BW'(RESET_CYC);

  // ---------------- link domain ----------------
  logic lrst_s1_reg, lrst_s2_reg, a0_s1_reg, a0_s2_reg;
  logic [3:0] bit_cnt_reg, bit_cnt_next;
  logic [2:0] byte_cnt_reg, byte_cnt_next;
  logic [7:0] shift_reg, shift_next, shift_in;
  logic active_reg, active_next, rw_reg, rw_next;
  logic [7:0] ptr_reg, ptr_next, msb_reg, msb_next;
  ioc_word_s word_reg, word_next;
  logic wr_tog_reg, wr_tog_next, ptr_tog_reg, ptr_tog_next;
  logic conv_tog_reg, conv_tog_next;
  logic [15:0] tx_reg, tx_next, rd_word_reg, rd_word_next;
  logic sda_rise_reg, start_reg, start_next, oe_reg, oe_next;
  logic addr_match, oe_gate_reg;

  // reset and address strap brought onto the link clock
  always_ff @(posedge scl_link) begin
    lrst_s1_reg <= rst_n;
    lrst_s2_reg <= lrst_s1_reg;
    a0_s1_reg <= addr_a0;
    a0_s2_reg <= a0_s1_reg;
  end

  assign addr_match = (shift_reg[7:1] == {SLAVE_ADDR_HI, a0_s2_reg});

  // byte framing on rising link edges
  always_comb begin
    bit_cnt_next = bit_cnt_reg;
    byte_cnt_next = byte_cnt_reg;
    shift_next = shift_reg;
    shift_in = {shift_reg[6:0], sda_in};
    active_next = active_reg;
    rw_next = rw_reg;
    ptr_next = ptr_reg;
    msb_next = msb_reg;
    word_next = word_reg;
    wr_tog_next = wr_tog_reg;
    ptr_tog_next = ptr_tog_reg;
    conv_tog_next = conv_tog_reg;
    tx_next = tx_reg;
    if (start_reg) begin
      shift_next = {7'h00, sda_in};
      bit_cnt_next = 4'h1;
      byte_cnt_next = 3'h0;
      active_next = 1'b0;
    end else if (bit_cnt_reg == 4'h8) begin
      bit_cnt_next = 4'h0;
      if (byte_cnt_reg != 3'h7) begin
        byte_cnt_next = byte_cnt_reg + 3'h1;
      end
      if (byte_cnt_reg == 3'h0) begin
        active_next = addr_match;
        rw_next = shift_reg[0];
        if (addr_match) begin
          conv_tog_next = ~conv_tog_reg;
          tx_next = rd_word_reg; // snapshot; word moves on pointer, result or input pins
        end
      end else if (rw_reg && sda_in) begin
        // a refused read byte ends the transfer, else the next bit could hold the wire low
        active_next = 1'b0;
      end
    end else begin
      shift_next = shift_in;
      bit_cnt_next = bit_cnt_reg + 4'h1;
      if (bit_cnt_reg == 4'h7 && active_reg && !rw_reg) begin
        case (byte_cnt_reg)
          3'h1: begin
            ptr_next = shift_in;
            ptr_tog_next = ~ptr_tog_reg;
          end
          3'h2: msb_next = shift_in;
          3'h3: begin
            word_next = '{ptr: ptr_reg, data: {msb_reg, shift_in}};
            wr_tog_next = ~wr_tog_reg;
          end
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge scl_link) begin
    if (!lrst_s2_reg) begin
      bit_cnt_reg <= 4'h0;
      byte_cnt_reg <= 3'h0;
      shift_reg <= 8'h00;
      active_reg <= 1'b0;
      rw_reg <= 1'b0;
      ptr_reg <= 8'h00;
      msb_reg <= 8'h00;
      word_reg <= '0;
      wr_tog_reg <= 1'b0;
      ptr_tog_reg <= 1'b0;
      conv_tog_reg <= 1'b0;
      tx_reg <= 16'h0000;
      sda_rise_reg <= 1'b1;
    end else begin
      bit_cnt_reg <= bit_cnt_next;
      byte_cnt_reg <= byte_cnt_next;
      shift_reg <= shift_next;
      active_reg <= active_next;
      rw_reg <= rw_next;
      ptr_reg <= ptr_next;
      msb_reg <= msb_next;
      word_reg <= word_next;
      wr_tog_reg <= wr_tog_next;
      ptr_tog_reg <= ptr_tog_next;
      conv_tog_reg <= conv_tog_next;
      tx_reg <= tx_next;
      sda_rise_reg <= sda_in;
    end
  end

  // start seen as data high at the rise, low at the fall; drive on the fall
  always_comb begin
    start_next = sda_rise_reg & ~sda_in;
    oe_next = 1'b0;
    if (start_next) begin
      oe_next = 1'b0;
    end else if (bit_cnt_reg == 4'h8) begin
      oe_next = (byte_cnt_reg == 3'h0) ? addr_match : (active_reg & ~rw_reg);
    end else if (active_reg && rw_reg && byte_cnt_reg != 3'h0) begin
      oe_next = ~tx_reg[{byte_cnt_reg[0], ~bit_cnt_reg[2:0]}]; // odd byte is high byte
    end
  end

  always_ff @(negedge scl_link) begin
    if (!lrst_s2_reg) begin
      start_reg <= 1'b0;
      oe_reg <= 1'b0;
    end else begin
      start_reg <= start_next;
      oe_reg <= oe_next;
    end
  end

  // open drain: only ever pull low, and never while the system is in reset
  assign sda_out = 1'b0;
  assign sda_oe = oe_reg & oe_gate_reg;

  // ---------------- system domain ----------------
  logic [2:0] wr_s_reg, ptr_s_reg, conv_s_reg, pin_s_reg;
  logic [7:0] io_s1_reg, io_s2_reg;
  logic wr_evt, ptr_evt, conv_evt, pin_fall, soft_rst, wr_ok, seq_load;
  logic [3:0] mode, nib;
  ioc_word_s w;
  ioc_cfg_s cfg_reg, cfg_next;
  logic [15:0] gp_reg, gp_next;
  logic hold_reg, hold_next, ref_reg, ref_next;
  logic [7:0][CODE_W-1:0] dac_in_reg, dac_in_next, dac_out_reg, dac_out_next;
  logic [7:0] rd_sel_reg, rd_sel_next;
  logic [BW-1:0] busy_reg, busy_next;

  // toggles, reset pin and pins cross through two flops
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wr_s_reg <= 3'h0;
      ptr_s_reg <= 3'h0;
      conv_s_reg <= 3'h0;
      pin_s_reg <= 3'h7;
      io_s1_reg <= 8'h00;
      io_s2_reg <= 8'h00;
      oe_gate_reg <= 1'b0;
    end else begin
      wr_s_reg <= {wr_s_reg[1:0], wr_tog_reg};
      ptr_s_reg <= {ptr_s_reg[1:0], ptr_tog_reg};
      conv_s_reg <= {conv_s_reg[1:0], conv_tog_reg};
      pin_s_reg <= {pin_s_reg[1:0], reset_pin_n};
      io_s1_reg <= io_in;
      io_s2_reg <= io_s1_reg;
      oe_gate_reg <= 1'b1;
    end
  end

  // word and pointer are stable for many link bits when their toggle lands
  assign wr_evt = wr_s_reg[2] ^ wr_s_reg[1];
  assign ptr_evt = ptr_s_reg[2] ^ ptr_s_reg[1];
  assign conv_evt = conv_s_reg[2] ^ conv_s_reg[1];
  assign pin_fall = pin_s_reg[2] & ~pin_s_reg[1];
  assign w = word_reg;
  assign mode = w.ptr[7:4];
  assign nib = w.ptr[3:0];
  assign soft_rst = pin_fall | (wr_evt && w.ptr == {MODE_CTRL, REG_SW_RESET}
                    && w.data == SWRST_PATTERN);
  // writes during the reset window are dropped
  assign wr_ok = wr_evt && busy_reg == '0 && !soft_rst;
  assign seq_load = wr_ok && w.ptr == {MODE_CTRL, REG_ADC_SEQ};

  // register file
  always_comb begin
    cfg_next = cfg_reg;
    gp_next = gp_reg;
    hold_next = hold_reg;
    ref_next = ref_reg;
    dac_in_next = dac_in_reg;
    dac_out_next = dac_out_reg;
    rd_sel_next = rd_sel_reg;
    busy_next = (busy_reg != '0) ? busy_reg - 1'b1 : busy_reg;
    if (ptr_evt) begin
      rd_sel_next = ptr_reg;
    end
    if (wr_ok && mode == MODE_DAC) begin
      dac_in_next[w.ptr[2:0]] = w.data[CODE_W-1:0];
      if (!hold_reg) begin
        dac_out_next[w.ptr[2:0]] = w.data[CODE_W-1:0];
      end
    end else if (wr_ok && mode == MODE_CTRL) begin
      case (nib)
        REG_GP_CTRL: gp_next = w.data;
        REG_ADC_CFG: if (!gp_reg[GP_LOCK_BIT]) cfg_next.adc_en = w.data[7:0];
        REG_DAC_CFG: if (!gp_reg[GP_LOCK_BIT]) cfg_next.dac_en = w.data[7:0];
        REG_GPO_CFG: if (!gp_reg[GP_LOCK_BIT]) cfg_next.gpo_en = w.data[7:0];
        REG_GPI_CFG: if (!gp_reg[GP_LOCK_BIT]) cfg_next.gpi_en = w.data[7:0];
        REG_GPO_DATA: cfg_next.gpo_data = w.data[7:0];
        REG_PWR_REF: ref_next = w.data[PWR_REF_EN_BIT];
        REG_DEFER: begin
          hold_next = w.data[DEFER_HOLD_BIT];
          if (w.data[DEFER_LOAD_BIT]) begin
            dac_out_next = dac_in_reg;
          end
        end
        default: ; // includes bad reset data: nothing moves
      endcase
    end
    if (soft_rst) begin
      cfg_next = CFG_RESET;
      gp_next = GP_RESET;
      hold_next = 1'b0;
      ref_next = 1'b0;
      dac_in_next = '0;
      dac_out_next = '0;
      rd_sel_next = 8'h00;
      busy_next = RST_C;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cfg_reg <= CFG_RESET;
      gp_reg <= GP_RESET;
      hold_reg <= 1'b0;
      ref_reg <= 1'b0;
      dac_in_reg <= '0;
      dac_out_reg <= '0;
      rd_sel_reg <= 8'h00;
      busy_reg <= '0;
    end else begin
      cfg_reg <= cfg_next;
      gp_reg <= gp_next;
      hold_reg <= hold_next;
      ref_reg <= ref_next;
      dac_in_reg <= dac_in_next;
      dac_out_reg <= dac_out_next;
      rd_sel_reg <= rd_sel_next;
      busy_reg <= busy_next;
    end
  end

  // ---------------- adc sequencer ----------------
  ioc_adc_state_e st_reg, st_next;
  logic [7:0] seq_reg, seq_next, tmr_reg, tmr_next;
  logic [2:0] ch_reg, ch_next;
  logic pend_reg, pend_next;
  logic [7:0][CODE_W-1:0] res_reg, res_next;

  // next set channel after c, wrapping round the mask
  function automatic logic [2:0] ioc_next_ch(input logic [7:0] m, input logic [2:0] c);
    logic [2:0] r;
    logic [2:0] k;
    r = c;
    for (int i = 7; i >= 1; i--) begin
      k = c + 3'(i);
      if (m[k]) begin
        r = k;
      end
    end
    return r;
  endfunction : ioc_next_ch

  always_comb begin
    st_next = st_reg;
    seq_next = seq_reg;
    tmr_next = tmr_reg;
    ch_next = ch_reg;
    pend_next = pend_reg;
    res_next = res_reg;
    case (st_reg)
      ADC_IDLE: ;
      ADC_TRACK: begin
        if (tmr_reg < TRK_C) begin
          tmr_next = tmr_reg + 8'h01;
        end
        if (conv_evt) begin
          pend_next = 1'b1;
        end
        // an early start waits out the least track time
        if ((conv_evt || pend_reg) && tmr_reg >= TRK_C) begin
          st_next = ADC_CONV;
          tmr_next = 8'h00;
          pend_next = 1'b0;
        end
      end
      ADC_CONV: begin
        tmr_next = tmr_reg + 8'h01;
        if (tmr_reg == CNV_C - 8'h01) begin
          res_next[ch_reg] = adc_code_in;
          ch_next = ioc_next_ch(seq_reg, ch_reg);
          st_next = ADC_TRACK;
          tmr_next = 8'h00;
        end
      end
      default: st_next = ADC_IDLE;
    endcase
    if (seq_load) begin
      seq_next = w.data[7:0];
      ch_next = ioc_next_ch(w.data[7:0], 3'h7);
      st_next = (w.data[7:0] != 8'h00) ? ADC_TRACK : ADC_IDLE;
      tmr_next = 8'h00;
      pend_next = 1'b0;
    end
    if (soft_rst) begin
      st_next = ADC_IDLE;
      seq_next = 8'h00;
      tmr_next = 8'h00;
      ch_next = 3'h0;
      pend_next = 1'b0;
      res_next = '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_reg <= ADC_IDLE;
      seq_reg <= 8'h00;
      tmr_reg <= 8'h00;
      ch_reg <= 3'h0;
      pend_reg <= 1'b0;
      res_reg <= '0;
    end else begin
      st_reg <= st_next;
      seq_reg <= seq_next;
      tmr_reg <= tmr_next;
      ch_reg <= ch_next;
      pend_reg <= pend_next;
      res_reg <= res_next;
    end
  end

  // readback word offered to the link
  always_comb begin
    rd_word_next = 16'h0000;
    if (rd_sel_reg == PTR_GPIO_RD) begin
      rd_word_next = {8'h00, io_s2_reg & cfg_reg.gpi_en};
    end else if (rd_sel_reg[7:4] == MODE_ADC_RD) begin
      rd_word_next = {1'b0, rd_sel_reg[2:0], res_reg[rd_sel_reg[2:0]]};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rd_word_reg <= 16'h0000;
    end else begin
      rd_word_reg <= rd_word_next;
    end
  end

  // outputs; the DAC wins a pin it shares with the output driver
  assign dac_code = dac_out_reg;
  assign dac_gain2 = gp_reg[GP_DAC_RANGE_BIT];
  assign adc_gain2 = gp_reg[GP_ADC_RANGE_BIT];
  assign ref_enable = ref_reg;
  assign dac_en = cfg_reg.dac_en;
  assign adc_en = cfg_reg.adc_en;
  assign pulldown_en = ~(cfg_reg.dac_en | cfg_reg.adc_en | cfg_reg.gpo_en | cfg_reg.gpi_en);
  assign io_out = cfg_reg.gpo_data;
  assign io_oe = cfg_reg.gpo_en & ~cfg_reg.dac_en;
  assign adc_mux_sel = ch_reg;
  assign adc_track = (st_reg == ADC_TRACK);
  assign adc_convert = (st_reg == ADC_CONV);
  assign reset_busy = (busy_reg != '0);

  // ---------------- checks ----------------
  a_range_shared: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wr_ok && w.ptr == {MODE_CTRL, REG_GP_CTRL} |=> dac_gain2 == $past(w.data[4])
    && adc_gain2 == $past(w.data[5])) else $error("range bits not taken");
  a_dac_direct: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wr_ok && mode == MODE_DAC && !hold_reg
    |=> dac_code[$past(w.ptr[2:0])] == $past(w.data[CODE_W-1:0]))
    else $error("dac not updated at once");
  a_dac_deferred: assert property (@(posedge clk_sys) disable iff (!rst_n)
    hold_reg && !soft_rst && !(wr_ok && w.ptr == {MODE_CTRL, REG_DEFER})
    |=> $stable(dac_code)) else $error("dac moved while held");
  a_seq_track: assert property (@(posedge clk_sys) disable iff (!rst_n)
    seq_load && w.data[7:0] != 8'h00 |=> (adc_track && !adc_convert) [*2])
    else $error("sequence write did not track");
  a_track_min: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(adc_convert) |-> $past(tmr_reg) >= TRK_C) else $error("track too short");
  a_conv_start: assert property (@(posedge clk_sys) disable iff (!rst_n)
    adc_track && conv_evt && tmr_reg >= TRK_C && !seq_load && !soft_rst
    |=> adc_convert) else $error("conversion did not start");
  a_conv_length: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $fell(adc_convert) && !$past(seq_load) && !$past(soft_rst)
    |-> $past(tmr_reg) == CNV_C - 8'h01) else $error("conversion length wrong");
  a_lock_cfg: assert property (@(posedge clk_sys) disable iff (!rst_n)
    gp_reg[GP_LOCK_BIT] && !soft_rst && nib != REG_GPO_DATA
    |=> $stable(cfg_reg)) else $error("locked config changed");
  a_swrst_bad: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wr_evt && w.ptr == {MODE_CTRL, REG_SW_RESET} && !soft_rst
    |=> $stable(cfg_reg) && $stable(gp_reg) && $stable(dac_code))
    else $error("bad reset data changed state");
  a_swrst_apply: assert property (@(posedge clk_sys) disable iff (!rst_n)
    soft_rst |=> reset_busy && cfg_reg == CFG_RESET && !ref_enable && !adc_track)
    else $error("reset not applied");
  a_busy_load: assert property (@(posedge clk_sys) disable iff (!rst_n)
    soft_rst |=> busy_reg == RST_C ##1 busy_reg == RST_C - 1'b1)
    else $error("reset window wrong");
  a_gpi_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
    rd_sel_reg == PTR_GPIO_RD && $stable(rd_sel_reg)
    |=> rd_word_reg[7:0] == $past(io_s2_reg & cfg_reg.gpi_en))
    else $error("input readback wrong");
  a_addr_ack: assert property (@(posedge scl_link) disable iff (!lrst_s2_reg)
    bit_cnt_reg == 4'h8 && byte_cnt_reg == 3'h0 && addr_match && !start_reg
    |=> conv_tog_reg != $past(conv_tog_reg)) else $error("no start at ack");
  c_conv_done: cover property (@(posedge clk_sys) disable iff (!rst_n)
    $fell(adc_convert) ##1 adc_track);
  c_soft_reset: cover property (@(posedge clk_sys) disable iff (!rst_n)
    soft_rst && !pin_fall);
  c_defer_load: cover property (@(posedge clk_sys) disable iff (!rst_n)
    hold_reg && wr_ok && w.ptr == {MODE_CTRL, REG_DEFER} && w.data[DEFER_LOAD_BIT]);
endmodule : ioc_channel_ctrl

// ### ioc_i2c_host_model.sv
module ioc_i2c_host_model
  import ioc_pkg::*;
(
  // link wires
  output logic scl_link,
  output logic sda,
  // device side of the open-drain data wire
  input wire logic dev_oe,
  input wire logic dev_out,
  input wire logic addr_a0
);
  timeunit 1ns;
  timeprecision 100ps;
  logic m_low = 1'b0;
  // pulled-up wire: low while either party pulls it, so no stale value survives a release
  assign sda = !(m_low || (dev_oe && !dev_out));
  initial scl_link = 1'b1;

  // one bit: data changes only while the clock is low
  task automatic clk_bit(input logic b, output logic seen);
    m_low = !b;
    #40;
    scl_link = 1'b1;
    #40;
    seen = sda;
    #40;
    scl_link = 1'b0;
    #40;
  endtask : clk_bit

  // the device sees a start only after a rise with data high, so a resting clock dips first
  task automatic start_cond();
    if (scl_link) begin
      scl_link = 1'b0;
      #40;
    end
    m_low = 1'b0;
    #40;
    scl_link = 1'b1;
    #40;
    m_low = 1'b1;
    #40;
    scl_link = 1'b0;
  endtask : start_cond

  // clock is left high afterwards: it stands still between frames
  task automatic stop_cond();
    m_low = 1'b1;
    #40;
    scl_link = 1'b1;
    #40;
    m_low = 1'b0;
    #80;
  endtask : stop_cond

  task automatic put_byte(input logic [7:0] v, inout int acks);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(v[i], s);
    clk_bit(1'b1, s);
    if (!s) acks++;
  endtask : put_byte

  task automatic get_byte(output logic [7:0] v, input logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(1'b1, v[i]);
    clk_bit(!ack, s);
  endtask : get_byte

  // free clocks with data high, to step the link's copy of reset in and out
  task automatic idle_clocks(input int n);
    repeat (n) begin
      #80 scl_link = 1'b0;
      #80 scl_link = 1'b1;
    end
  endtask : idle_clocks

  // small offset keeps the link edges apart from the system clock edges
  task automatic write_frame(input logic [7:0] ptr, input logic [15:0] data, input int nbytes,
      output int acks);
    acks = 0;
    #7;
    start_cond();
    put_byte({SLAVE_ADDR_HI, addr_a0, 1'b0}, acks);
    put_byte(ptr, acks);
    if (nbytes == 3) begin
      put_byte(data[15:8], acks);
      put_byte(data[7:0], acks);
    end
    stop_cond();
  endtask : write_frame

  task automatic read_frame(input logic [7:0] ptr, output logic [15:0] data, output int acks);
    acks = 0;
    #7;
    start_cond();
    put_byte({SLAVE_ADDR_HI, addr_a0, 1'b0}, acks);
    put_byte(ptr, acks);
    start_cond();
    put_byte({SLAVE_ADDR_HI, addr_a0, 1'b1}, acks);
    get_byte(data[15:8], 1'b1);
    get_byte(data[7:0], 1'b0);
    stop_cond();
  endtask : read_frame
endmodule : ioc_i2c_host_model

// ### ioc_pkg.sv
package ioc_pkg;
  // timing, in printed units and in cycles of clk_sys
  localparam int CLK_PERIOD_NS = 20;
  localparam int TRACK_MIN_NS = 500;
  localparam int TRACK_CYCLES = (TRACK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_TIME_US = 2;
  localparam int CONV_CYCLES = CONV_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int RESET_TIME_US = 250;
  localparam int RESET_CYCLES = RESET_TIME_US * 1000 / CLK_PERIOD_NS;

  // serial link
  localparam logic [5:0] SLAVE_ADDR_HI = 6'h08;

  // pointer byte
  localparam logic [3:0] MODE_CTRL = 4'h0;
  localparam logic [3:0] MODE_DAC = 4'h1;
  localparam logic [3:0] MODE_ADC_RD = 4'h4;
  localparam logic [7:0] PTR_GPIO_RD = 8'h60;

  // control register selects
  localparam logic [3:0] REG_ADC_SEQ = 4'h2;
  localparam logic [3:0] REG_GP_CTRL = 4'h3;
  localparam logic [3:0] REG_ADC_CFG = 4'h4;
  localparam logic [3:0] REG_DAC_CFG = 4'h5;
  localparam logic [3:0] REG_DEFER = 4'h7;
  localparam logic [3:0] REG_GPO_CFG = 4'h8;
  localparam logic [3:0] REG_GPO_DATA = 4'h9;
  localparam logic [3:0] REG_GPI_CFG = 4'ha;
  localparam logic [3:0] REG_PWR_REF = 4'hb;
  localparam logic [3:0] REG_SW_RESET = 4'hf;
  localparam logic [15:0] SWRST_PATTERN = 16'h0dac;

  // field positions
  localparam int GP_DAC_RANGE_BIT = 4;
  localparam int GP_ADC_RANGE_BIT = 5;
  localparam int GP_LOCK_BIT = 7;
  localparam int PWR_REF_EN_BIT = 9;
  localparam int DEFER_HOLD_BIT = 0;
  localparam int DEFER_LOAD_BIT = 1;

  typedef struct packed {
    logic [7:0] dac_en;
    logic [7:0] adc_en;
    logic [7:0] gpo_en;
    logic [7:0] gpi_en;
    logic [7:0] gpo_data;
  } ioc_cfg_s;

  typedef struct packed {
    logic [7:0] ptr;
    logic [15:0] data;
  } ioc_word_s;

  typedef enum logic [1:0] {
    ADC_IDLE = 2'b00,
    ADC_TRACK = 2'b01,
    ADC_CONV = 2'b10
  } ioc_adc_state_e;

  // values after reset
  localparam ioc_cfg_s CFG_RESET = '0;
  localparam logic [15:0] GP_RESET = 16'h0000;
endpackage : ioc_pkg

// ### test_ioc_channel_ctrl.sv
`define CHK(got, exp) \
  begin \
    check_count++; \
    if ((got) !== (exp)) begin \
      err_count++; \
      $display("ERROR at %0t: got %h expected %h", $time, (got), (exp)); \
    end \
  end

module test_ioc_channel_ctrl
  import ioc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys, rst_n, scl_link, sda, sda_out, sda_oe, reset_pin_n;
  logic dac_gain2, adc_gain2, ref_enable, adc_track, adc_convert, reset_busy;
  logic [7:0][11:0] dac_code;
  logic [7:0] dac_en, adc_en, pulldown_en, io_in, io_out, io_oe;
  logic [2:0] adc_mux_sel;
  logic [11:0] adc_code_in;
  logic [15:0] d;
  int err_count = 0;
  int check_count = 0;
  int acks, n;

  ioc_channel_ctrl #(.RESET_CYC(20)) ioc_channel_ctrl_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .scl_link(scl_link), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .addr_a0(1'b0), .reset_pin_n(reset_pin_n),
    .dac_code(dac_code), .dac_gain2(dac_gain2), .adc_gain2(adc_gain2),
    .ref_enable(ref_enable), .dac_en(dac_en), .adc_en(adc_en), .pulldown_en(pulldown_en),
    .adc_mux_sel(adc_mux_sel), .adc_track(adc_track), .adc_convert(adc_convert),
    .adc_code_in(adc_code_in), .io_in(io_in), .io_out(io_out), .io_oe(io_oe),
    .reset_busy(reset_busy)
  );

  ioc_i2c_host_model ioc_i2c_host_model_inst (
    .scl_link(scl_link), .sda(sda), .dev_oe(sda_oe), .dev_out(sda_out), .addr_a0(1'b0)
  );

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic settle(input int c);
    repeat (c) @(posedge clk_sys);
    #1;
  endtask : settle

  task automatic wr(input logic [7:0] ptr, input logic [15:0] data);
    ioc_i2c_host_model_inst.write_frame(ptr, data, 3, acks);
    `CHK(acks, 4)
    settle(8);
  endtask : wr

  task automatic rd(input logic [7:0] ptr, output logic [15:0] data);
    ioc_i2c_host_model_inst.read_frame(ptr, data, acks);
    settle(4);
  endtask : rd

  // cycles a level stays high, with bounded waits on both sides
  task automatic span(ref logic sig, output int cnt);
    cnt = 0;
    while (sig !== 1'b1 && cnt < 400) begin
      @(posedge clk_sys);
      #1;
      cnt++;
    end
    cnt = 0;
    while (sig === 1'b1 && cnt < 400) begin
      @(posedge clk_sys);
      #1;
      cnt++;
    end
  endtask : span

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish

  // watchdog: the whole sequence needs well under a third of this
  initial begin
    #1_000_000;
    err_count++;
    tally_and_finish();
  end

  initial begin
    rst_n = 1'b0;
    reset_pin_n = 1'b1;
    io_in = 8'ha5;
    adc_code_in = 12'h5a5;
    // link logic resets only on its own edges, so clock it during reset
    fork
      repeat (10) @(posedge clk_sys);
      ioc_i2c_host_model_inst.idle_clocks(4);
    join
    @(posedge clk_sys);
    #1 rst_n = 1'b1;
    // the link holds its own reset until two of its rises have seen the release
    ioc_i2c_host_model_inst.idle_clocks(2);
    settle(2);
    `CHK(pulldown_en, 8'hff)
    `CHK(ref_enable, 1'b0)
    $display("test reset_defaults done");
    wr(8'h0b, 16'h0200);
    `CHK(ref_enable, 1'b1)
    wr(8'h03, 16'h0010);
    `CHK({adc_gain2, dac_gain2}, 2'b01)
    wr(8'h03, 16'h0020);
    `CHK({adc_gain2, dac_gain2}, 2'b10)
    $display("test ranges done");
    wr(8'h05, 16'h0005);
    wr(8'h10, 16'h0fff);
    `CHK(dac_code[0], 12'hfff)
    wr(8'h12, 16'h0800);
    `CHK(dac_code[2], 12'h800)
    wr(8'h07, 16'h0001);
    wr(8'h10, 16'h0123);
    `CHK(dac_code[0], 12'hfff)
    wr(8'h07, 16'h0002);
    `CHK(dac_code[0], 12'h123)
    $display("test dac done");
    wr(8'h04, 16'h000c);
    wr(8'h02, 16'h000c);
    `CHK({adc_track, adc_mux_sel}, 4'hA)
    `CHK({dac_en, adc_en}, 16'h050c)
    settle(30);
    fork
      ioc_i2c_host_model_inst.write_frame(8'h42, 16'h0000, 1, acks);
      span(adc_convert, n);
    join
    `CHK(n, CONV_CYCLES)
    settle(2);
    `CHK(adc_mux_sel, 3'd3)
    rd(8'h42, d);
    `CHK(d, 16'h25a5)
    $display("test adc done");
    wr(8'h08, 16'h0030);
    wr(8'h09, 16'h0010);
    `CHK(io_oe, 8'h30)
    `CHK(io_out[5:4], 2'b01)
    wr(8'h0a, 16'h0060);
    `CHK(pulldown_en, 8'h82)
    rd(8'h60, d);
    `CHK(d, 16'h0020)
    wr(8'h03, 16'h0080);
    wr(8'h08, 16'h00ff);
    `CHK(io_oe, 8'h30)
    $display("test gpio_lock done");
    wr(8'h0f, 16'h1234);
    `CHK({ref_enable, io_oe}, 9'h130)
    fork
      ioc_i2c_host_model_inst.write_frame(8'h0f, SWRST_PATTERN, 3, acks);
      span(reset_busy, n);
    join
    `CHK(n, 20)
    settle(2);
    `CHK({ref_enable, io_oe, pulldown_en}, 17'h000ff)
    wr(8'h0b, 16'h0200);
    `CHK(ref_enable, 1'b1)
    reset_pin_n = 1'b0;
    settle(5);
    `CHK({reset_busy, ref_enable}, 2'b10)
    reset_pin_n = 1'b1;
    settle(25);
    `CHK(reset_busy, 1'b0)
    $display("test resets done");
    tally_and_finish();
  end
endmodule : test_ioc_channel_ctrl
